// >>> rtl/sram_port_pkg.sv
// Timing constants, widths and modes for the asynchronous SRAM module host controller
package sram_port_pkg;

    localparam int CLK_PERIOD_PS = 5000;        // 200 MHz reference clock
    localparam int ADDR_W        = 19;          // 512K words
    localparam int DATA_W        = 32;          // Word width
    localparam int LANES         = 4;           // Byte lanes

    // Speed grade selector: 0, 1, 2 for the three grades
    localparam int GRADE_W       = 2;

    // Read timing in ns per grade
    localparam int T_RC_NS [3]   = '{35, 45, 55};   // Read cycle / address access
    localparam int T_OE_NS [3]   = '{15, 17, 22};   // Output gate to data
    localparam int T_OHA_NS      = 5;               // Data hold after address change
    localparam int T_PD_NS [3]   = '{35, 45, 55};   // Select high to power-down

    // Write timing in ns per grade
    localparam int T_SD_NS [3]   = '{20, 25, 35};   // Data setup to write end
    localparam int T_AW_NS [3]   = '{30, 40, 50};   // Address setup to write end
    localparam int T_HD_NS       = 7;               // Data hold after write end
    localparam int T_HA_NS       = 5;               // Address hold after write end
    localparam int T_SA_NS       = 2;               // Address setup to write start

    // Least times round up to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int CNT_W = 5;                   // Wide enough for every count

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RADDR  = 3'b001,
        ST_RWAIT  = 3'b010,
        ST_WSETUP = 3'b011,
        ST_WPULSE = 3'b100,
        ST_WHOLD  = 3'b101,
        ST_REC    = 3'b110
    } state_t;

endpackage : sram_port_pkg

// >>> rtl/cycle_timer.sv
// Loadable down counter giving a one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none
module cycle_timer (
    input  wire logic                           ref_clk,  // System clock
    input  wire logic                           reset,    // Synchronous, active high
    input  wire logic                           load,     // Load new count
    input  wire logic [sram_port_pkg::CNT_W-1:0] count,   // Cycles to wait
    output logic                                done      // Pulse when count expires
);

    logic [sram_port_pkg::CNT_W-1:0] remain;
    logic [sram_port_pkg::CNT_W-1:0] next_remain;
    logic                            next_done;

    // Count down after a load, flag the last cycle
    always_comb begin
        next_remain = remain;
        next_done   = 1'b0;
        if (load) begin
            next_remain = count;
        end else if (remain != '0) begin
            next_remain = remain - 1'b1;
            next_done   = (remain == 5'h01);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            remain <= '0;
            done   <= 1'b0;
        end else begin
            remain <= next_remain;
            done   <= next_done;
        end
    end

endmodule : cycle_timer
`default_nettype wire

// >>> rtl/sram_host_ctrl.sv
// Host controller driving an asynchronous 512K x 32 SRAM module through its pins
`timescale 1ns/10ps
`default_nettype none
// Contract
// RL1: Memory holds 512K words of 32 bits, word addressed.
// RL2: Four active-low lane selects enable bytes independently, any combination.
// RL3: Lane deselected when select high; read with gate low; write with strobe low.
// RL4: Write strobe stays high throughout every read cycle.
// RL5: Read data valid within grade access time after stable address.
// RL6: Previous read data held at least 5 ns after address change.
// RL7: Read data valid within grade access time after select falls.
// RL8: Read data valid within 15, 17 or 22 ns after gate falls.
// RL9: Lane powers down within grade time after select rises.
// RL10: Write begins only with select and strobe both low; overlap is write.
// RL11: Write ends at first of select rising or strobe rising.
// RL12: Write data valid 20, 25 or 35 ns before write end.
// RL13: Write data held at least 7 ns after write end.
// RL14: Address stable 30, 40 or 50 ns before write end.
// RL15: Address unchanged at least 5 ns after write end.
// RL16: Address stable at least 2 ns before write begins.
// RL17: Address valid no later than select falling edge for reads.
// RL18: Select and strobe rising together leave the data lines floating.
module sram_host_ctrl (
    input  wire logic                                ref_clk,     // 200 MHz clock
    input  wire logic                                reset,       // Synchronous, active high
    input  wire logic [sram_port_pkg::GRADE_W-1:0]   speed_grade, // 0..2, sampled per access
    input  wire logic                                req_valid,   // Access request
    input  wire logic                                req_write,   // 1 write, 0 read
    input  wire logic [sram_port_pkg::ADDR_W-1:0]    req_addr,    // Word address
    input  wire logic [sram_port_pkg::LANES-1:0]     req_lanes,   // Byte lanes, active high
    input  wire logic [sram_port_pkg::DATA_W-1:0]    req_wdata,   // Write data
    output logic                                     req_ready,   // Idle, request accepted
    output logic                                     rsp_valid,   // Access complete pulse
    output logic [sram_port_pkg::DATA_W-1:0]         rsp_rdata,   // Read data
    output logic [sram_port_pkg::ADDR_W-1:0]         mem_addr,    // Address pins
    output logic [sram_port_pkg::LANES-1:0]          sel_n,       // Lane selects, active low
    output logic                                     wstrobe_n,   // Write strobe, active low
    output logic                                     ogate_n,     // Output gate, active low
    input  wire logic [sram_port_pkg::DATA_W-1:0]    data_in,     // Data pins, input side
    output logic [sram_port_pkg::DATA_W-1:0]         data_out,    // Data pins, output side
    output logic [sram_port_pkg::LANES-1:0]          data_oe      // Per-lane drive enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts, grade-dependent except c_sa and c_hold

    logic [sram_port_pkg::GRADE_W-1:0] grade;
    logic [sram_port_pkg::GRADE_W-1:0] next_grade;
    logic [sram_port_pkg::CNT_W-1:0]   c_read;
    logic [sram_port_pkg::CNT_W-1:0]   c_pulse;
    logic [sram_port_pkg::CNT_W-1:0]   c_sa;
    logic [sram_port_pkg::CNT_W-1:0]   c_hold;
    logic [sram_port_pkg::CNT_W-1:0]   c_pd;
    int                                gi;

    // Pulse covers both address-to-end and data-to-end setup
    always_comb begin
        gi      = (grade > 2'h2) ? 2 : int'(grade);
        c_read  = sram_port_pkg::CNT_W'(sram_port_pkg::cyc_up(sram_port_pkg::T_RC_NS[gi]));
        c_pulse = sram_port_pkg::CNT_W'(sram_port_pkg::cyc_up(
                      (sram_port_pkg::T_AW_NS[gi] > sram_port_pkg::T_SD_NS[gi]) ?
                      sram_port_pkg::T_AW_NS[gi] : sram_port_pkg::T_SD_NS[gi])); // [RL12] [RL14]
        c_sa    = sram_port_pkg::CNT_W'(sram_port_pkg::cyc_up(sram_port_pkg::T_SA_NS));
        c_hold  = sram_port_pkg::CNT_W'(sram_port_pkg::cyc_up(
                      (sram_port_pkg::T_HD_NS > sram_port_pkg::T_HA_NS) ?
                      sram_port_pkg::T_HD_NS : sram_port_pkg::T_HA_NS)); // [RL13] [RL15]
        c_pd    = sram_port_pkg::CNT_W'(sram_port_pkg::cyc_up(sram_port_pkg::T_PD_NS[gi]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer

    logic                            t_load;
    logic [sram_port_pkg::CNT_W-1:0] t_count;
    logic                            t_done;

    cycle_timer u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (t_load),
        .count   (t_count),
        .done    (t_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    sram_port_pkg::state_t             state;
    sram_port_pkg::state_t             next_state;
    logic [sram_port_pkg::ADDR_W-1:0]  next_mem_addr;
    logic [sram_port_pkg::LANES-1:0]   next_sel_n;
    logic                              next_wstrobe_n;
    logic                              next_ogate_n;
    logic [sram_port_pkg::DATA_W-1:0]  next_data_out;
    logic [sram_port_pkg::LANES-1:0]   next_data_oe;
    logic [sram_port_pkg::LANES-1:0]   lanes;
    logic [sram_port_pkg::LANES-1:0]   next_lanes;
    logic                              next_req_ready;
    logic                              next_rsp_valid;
    logic [sram_port_pkg::DATA_W-1:0]  next_rsp_rdata;

    // Next pin and state values
    always_comb begin
        next_state     = state;
        next_mem_addr  = mem_addr;
        next_sel_n     = sel_n;
        next_wstrobe_n = wstrobe_n;
        next_ogate_n   = ogate_n;
        next_data_out  = data_out;
        next_data_oe   = data_oe;
        next_lanes     = lanes;
        next_grade     = grade;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        t_load         = 1'b0;
        t_count        = c_read;
        case (state)
            sram_port_pkg::ST_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_mem_addr  = req_addr; // [RL1]
                    next_lanes     = req_lanes;
                    next_grade     = speed_grade;
                    next_state     = req_write ? sram_port_pkg::ST_WSETUP
                                               : sram_port_pkg::ST_RADDR;
                    if (req_write) begin
                        next_data_out = req_wdata;
                    end
                end
            end
            sram_port_pkg::ST_RADDR: begin
                // Address already on pins one cycle before select falls
                next_sel_n     = ~lanes;                 // [RL2] [RL17]
                next_ogate_n   = 1'b0;                   // [RL3]
                next_wstrobe_n = 1'b1;                   // [RL4]
                t_load         = 1'b1;
                t_count        = c_read;                 // [RL5] [RL7] [RL8]
                next_state     = sram_port_pkg::ST_RWAIT;
            end
            sram_port_pkg::ST_RWAIT: begin
                if (t_done) begin
                    // Sample before address or select moves
                    next_rsp_rdata = data_in;            // [RL6]
                    next_rsp_valid = 1'b1;
                    next_sel_n     = '1;
                    next_ogate_n   = 1'b1;
                    t_load         = 1'b1;
                    t_count        = c_pd;               // [RL9]
                    next_state     = sram_port_pkg::ST_REC;
                end
            end
            sram_port_pkg::ST_WSETUP: begin
                // Drive data and select, strobe waits for address setup
                next_sel_n   = ~lanes;                   // [RL2]
                next_ogate_n = 1'b1;
                next_data_oe = lanes;
                t_load       = 1'b1;
                t_count      = c_sa;                     // [RL16]
                next_state   = sram_port_pkg::ST_WPULSE;
            end
            sram_port_pkg::ST_WPULSE: begin
                if (t_done && wstrobe_n) begin
                    next_wstrobe_n = 1'b0;               // [RL10]
                    t_load         = 1'b1;
                    t_count        = c_pulse;
                end else if (t_done) begin
                    // Strobe alone ends the write; select rises later
                    next_wstrobe_n = 1'b1;               // [RL11] [RL18]
                    t_load         = 1'b1;
                    t_count        = c_hold;
                    next_state     = sram_port_pkg::ST_WHOLD;
                end
            end
            sram_port_pkg::ST_WHOLD: begin
                if (t_done) begin
                    next_sel_n     = '1;                 // [RL3]
                    next_data_oe   = '0;
                    next_rsp_valid = 1'b1;
                    t_load         = 1'b1;
                    t_count        = c_pd;
                    next_state     = sram_port_pkg::ST_REC;
                end
            end
            sram_port_pkg::ST_REC: begin
                if (t_done) begin
                    next_state     = sram_port_pkg::ST_IDLE;
                    next_req_ready = 1'b1;
                end
            end
            default: begin
                next_state = sram_port_pkg::ST_IDLE;
            end
        endcase
    end

    // Register all state and pins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state     <= sram_port_pkg::ST_IDLE;
            mem_addr  <= '0;
            sel_n     <= '1;
            wstrobe_n <= 1'b1;
            ogate_n   <= 1'b1;
            data_out  <= '0;
            data_oe   <= '0;
            lanes     <= '0;
            grade     <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            state     <= next_state;
            mem_addr  <= next_mem_addr;
            sel_n     <= next_sel_n;
            wstrobe_n <= next_wstrobe_n;
            ogate_n   <= next_ogate_n;
            data_out  <= next_data_out;
            data_oe   <= next_data_oe;
            lanes     <= next_lanes;
            grade     <= next_grade;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
        end
    end

endmodule : sram_host_ctrl
`default_nettype wire

// >>> dv/sram_module_model.sv
// Behavioural model of the 512K x 32 asynchronous SRAM module
`timescale 1ns/10ps
`default_nettype none
module sram_module_model #(
    parameter int ACC_NS = 30                            // Access delay, below every grade
) (
    input  wire logic [sram_port_pkg::ADDR_W-1:0] mem_addr,  // Address pins
    input  wire logic [sram_port_pkg::LANES-1:0]  sel_n,     // Lane selects
    input  wire logic                             wstrobe_n, // Write strobe
    input  wire logic                             ogate_n,   // Output gate
    input  wire logic [sram_port_pkg::DATA_W-1:0] data_out,  // Host drive value
    input  wire logic [sram_port_pkg::LANES-1:0]  data_oe,   // Host drive enables
    output logic      [sram_port_pkg::DATA_W-1:0] data_in    // Resolved data pins
);
    logic [31:0] mem [logic [18:0]];                      // Sparse word store
    logic [31:0] rd;
    ////////////////////////////////////////////////////////////////////////////////
    // Stored word appears after the access delay, old word held until then
    // Select changes re-read too, so a word written in place is seen later
    always @(mem_addr or sel_n) begin
        rd <= #(ACC_NS) (mem.exists(mem_addr) ? mem[mem_addr] : 32'h00000000);
    end
    // Each lane shows host drive, read data, or a float pattern
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (data_oe[k])
                data_in[8*k+:8] = data_out[8*k+:8];
            else if (!sel_n[k] && wstrobe_n && !ogate_n)
                data_in[8*k+:8] = rd[8*k+:8];
            else
                data_in[8*k+:8] = ~rd[8*k+:8];
        end
    end
    // Write lands at the strobe rise on selected lanes only
    always @(posedge wstrobe_n) begin
        if (sel_n != 4'hF) begin
            if (!mem.exists(mem_addr))
                mem[mem_addr] = 32'h00000000;
            for (int k = 0; k < 4; k++) begin
                if (!sel_n[k])
                    mem[mem_addr][8*k+:8] = data_in[8*k+:8];
            end
        end
    end
endmodule : sram_module_model
`default_nettype wire

// >>> dv/sram_host_ctrl_assertions.sv
// Pin timing checker for the SRAM host controller
`timescale 1ns/10ps
`default_nettype none
module sram_host_ctrl_assertions (
    input wire logic                             ref_clk,     // Clock
    input wire logic                             reset,       // Reset
    input wire logic [sram_port_pkg::GRADE_W-1:0] speed_grade, // Grade
    input wire logic                             req_valid,   // Request
    input wire logic                             req_ready,   // Ready
    input wire logic                             rsp_valid,   // Done pulse
    input wire logic [sram_port_pkg::ADDR_W-1:0] mem_addr,    // Address pins
    input wire logic [sram_port_pkg::LANES-1:0]  sel_n,       // Lane selects
    input wire logic                             wstrobe_n,   // Write strobe
    input wire logic                             ogate_n,     // Output gate
    input wire logic [sram_port_pkg::DATA_W-1:0] data_out,    // Drive value
    input wire logic [sram_port_pkg::LANES-1:0]  data_oe      // Drive enables
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin relations
    a_read_strobe_high: assert property (!ogate_n |-> wstrobe_n && data_oe == 4'h0)
        else $error("strobe or drive active during read");
    a_addr_held_sel: assert property (sel_n != 4'hF |-> $stable(mem_addr))
        else $error("address moved while selected");
    a_no_joint_rise: assert property ($rose(wstrobe_n) |-> sel_n == $past(sel_n))
        else $error("select rose with strobe");
    a_write_lanes: assert property (!wstrobe_n |-> sel_n != 4'hF && data_oe == ~sel_n)
        else $error("strobe low without matching lanes");
    a_write_hold: assert property ($rose(wstrobe_n) |-> ($stable(data_out) && data_oe != 4'h0)[*2])
        else $error("write data not held after strobe rise");
    a_strobe_width: assert property ($fell(wstrobe_n) |-> (!wstrobe_n && $stable(data_out))[*6])
        else $error("write pulse too short");
    a_read_window: assert property ($fell(ogate_n) |-> (!ogate_n && $stable(mem_addr))[*7])
        else $error("read window too short");
    a_recovery_wait: assert property (rsp_valid |-> (!req_ready)[*7])
        else $error("ready too soon after access");
    a_answer_bound: assert property (req_valid && req_ready |-> ##[9:18] rsp_valid)
        else $error("access did not complete in time");
    c_read: cover property ($fell(ogate_n));
    c_write: cover property ($rose(wstrobe_n));
    c_slow_grade: cover property (rsp_valid && speed_grade == 2'h3);
endmodule : sram_host_ctrl_assertions
bind sram_host_ctrl sram_host_ctrl_assertions i_sram_host_ctrl_assertions (.ref_clk, .reset,
    .speed_grade, .req_valid, .req_ready, .rsp_valid, .mem_addr, .sel_n, .wstrobe_n,
    .ogate_n, .data_out, .data_oe);
`default_nettype wire

// >>> dv/async_sram_module_port_tb.sv
// Self-checking bench of the SRAM host controller with its memory model
`timescale 1ns/10ps
`default_nettype none
module async_sram_module_port_tb;
    typedef struct packed {
        logic        wr;     // Write when set
        logic [1:0]  grade;  // Speed grade
        logic [18:0] addr;   // Word address
        logic [3:0]  lanes;  // Byte lanes
        logic [31:0] data;   // Write data, or expected read
    } row_t;
    logic        ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0]  speed_grade = 2'h0;
    logic [18:0] req_addr = 19'h00000, mem_addr;
    logic [3:0]  req_lanes = 4'h0, sel_n, data_oe;
    logic [31:0] req_wdata = 32'h00000000, rsp_rdata, data_in, data_out;
    logic        req_ready, rsp_valid, wstrobe_n, ogate_n;
    int          fail_count = 0, cmp_count = 0;
    row_t rows [6] = '{'{1'b1, 2'h0, 19'h00000, 4'hF, 32'h11223344},
                       '{1'b0, 2'h1, 19'h00000, 4'hF, 32'h11223344},
                       '{1'b1, 2'h2, 19'h7FFFF, 4'h5, 32'hAABBCCDD},
                       '{1'b0, 2'h0, 19'h7FFFF, 4'hF, 32'h00BB00DD},
                       '{1'b1, 2'h3, 19'h00000, 4'hA, 32'h55667788},
                       '{1'b0, 2'h1, 19'h00000, 4'h2, 32'h00007700}};
    sram_host_ctrl i_sram_host_ctrl (.ref_clk, .reset, .speed_grade, .req_valid, .req_write,
        .req_addr, .req_lanes, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
        .sel_n, .wstrobe_n, .ogate_n, .data_in, .data_out, .data_oe);
    sram_module_model i_sram_module_model (.mem_addr, .sel_n, .wstrobe_n, .ogate_n,
        .data_out, .data_oe, .data_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons, access driver and closing
    task automatic chk_data(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk_data
    task automatic chk_pins(input string name, input logic [10:0] e, input logic [10:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk_pins
    task automatic access(input row_t r);
        int n = 0;
        req_valid   <= 1'b1;
        req_write   <= r.wr;
        speed_grade <= r.grade;
        req_addr    <= r.addr;
        req_lanes   <= r.lanes;
        req_wdata   <= r.data;
        // Outputs are looked at mid-cycle, inputs change on the rising edge
        do begin
            @(negedge ref_clk);
            n++;
        end while (!req_ready && n < 200);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!rsp_valid && n < 400);
        @(posedge ref_clk);
        if (n >= 400)
            fail_count++;
    endtask : access
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // Clock and watchdog
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        chk_pins("idle pins", 11'h7E0, {sel_n, wstrobe_n, ogate_n, data_oe, req_ready});
        reset <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            access(rows[i]);
            if (!rows[i].wr)
                chk_data("read word", rows[i].data, rsp_rdata & {{8{rows[i].lanes[3]}},
                    {8{rows[i].lanes[2]}}, {8{rows[i].lanes[1]}}, {8{rows[i].lanes[0]}}});
        end
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr  <= 19'h00000;
        repeat (30) @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        req_valid <= 1'b0;
        @(posedge ref_clk);
        chk_pins("reset pins", 11'h7E0, {sel_n, wstrobe_n, ogate_n, data_oe, req_ready});
        reset <= 1'b0;
        @(posedge ref_clk);
        access(rows[3]);
        chk_data("read after reset", 32'h00BB00DD, rsp_rdata);
        stop_test();
    end
endmodule : async_sram_module_port_tb
`default_nettype wire
